// ===== verilog/dtb_top.sv
// debug trace and break unit: registers, run control, capture and breaks
`timescale 1ns/1ps
`default_nettype none
`include "dtb_consts.svh"

// Function
// - user writes to host reset register ignored
// - host reset register always reads zero
// - host writing bit 0 forces system reset, once per reset
// - four comparator bytes clear on reset
// - comparator bytes writable only while disarmed
// - both fifo byte ports are read only
// - event-only modes: upper fifo byte reads zero
// - upper fifo read does not advance fifo
// - lower fifo read advances to next word
// - armed: lower reads do not advance fifo
// - disarmed lower read stores last opcode address
// - profiling fifo is an eight-entry delay
// - control register accessible at any time
// - enable cannot be set while secured
// - arm sets run flag, cleared at completion
// - writing zero to arm or enable ends run
// - tag bit selects force or tag break
// - end trace breaks on trigger condition
// - begin trace breaks when fifo fills
// - comparator A direction qualification
// - comparator B direction qualification
// - run completes on full or end trigger
module dtb_top #(
    parameter int AW = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire dtb_pkg::dtb_req_t reg_req,
    output logic [7:0] reg_rdata,
    // observed cpu bus
    input wire dtb_pkg::dtb_cpu_t cpu_bus,
    // trigger mode set elsewhere
    input wire logic mode_begin_trace,
    input wire logic mode_event_only,
    input wire logic secure_state,
    // status
    output logic run_active_flag,
    output logic [3:0] fifo_valid_count,
    // break and reset requests
    output logic break_req,
    output logic break_is_tag,
    output logic sys_reset_req
);

    // ****************************************
    // state and helper signals
    // ****************************************
    dtb_pkg::dtb_state_t state_ff;
    dtb_pkg::dtb_state_t nxt_state;
    logic match_a;
    logic match_b;
    logic trigger;
    logic fifo_clear;
    logic fifo_shift;
    logic [15:0] fifo_din;
    logic [15:0] fifo_head;
    logic [3:0] fifo_count;
    logic fifo_full;
    logic wr_ctrl;
    logic rd_lower;
    logic begin_like;
    logic store_now;
    logic run_done;
    dtb_pkg::dtb_ctrl_t wctrl;

    // ****************************************
    // comparators A and B
    // ****************************************
    dtb_comparator #(
        .AW(AW)
    ) u_cmp_a (
        .cmp_value(state_ff.cmp_a),
        .dir_qualify(state_ff.ctrl.cmp_a_direction_qualify),
        .dir_value(state_ff.ctrl.cmp_a_direction_value),
        .bus_addr(cpu_bus.addr),
        .bus_valid(cpu_bus.valid),
        .bus_is_read(cpu_bus.is_read),
        .match(match_a)
    );

    dtb_comparator #(
        .AW(AW)
    ) u_cmp_b (
        .cmp_value(state_ff.cmp_b),
        .dir_qualify(state_ff.ctrl.cmp_b_direction_qualify),
        .dir_value(state_ff.ctrl.cmp_b_direction_value),
        .bus_addr(cpu_bus.addr),
        .bus_valid(cpu_bus.valid),
        .bus_is_read(cpu_bus.is_read),
        .match(match_b)
    );

    // ****************************************
    // trace buffer
    // ****************************************
    dtb_trace_fifo #(
        .W(`DTB_FIFO_WIDTH),
        .DEPTH(`DTB_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(fifo_clear),
        .shift(fifo_shift),
        .din(fifo_din),
        .head(fifo_head),
        .count(fifo_count),
        .full(fifo_full)
    );

    // ****************************************
    // capture and run completion
    // ****************************************
    // the trigger itself is a plain A-or-B match; finer trigger modes live elsewhere
    always_comb begin
        trigger = match_a | match_b;
        // event-only modes always behave as begin traces
        begin_like = mode_begin_trace | mode_event_only;
        wr_ctrl = reg_req.wr && (reg_req.sel == `DTB_IDX_CONTROL);
        rd_lower = reg_req.rd && (reg_req.sel == `DTB_IDX_FIFO_LOWER);
        wctrl = dtb_pkg::dtb_ctrl_t'(reg_req.wdata);
        store_now = 1'b0;
        run_done = 1'b0;
        if (state_ff.run_active_flag && state_ff.ctrl.debug_unit_enable) begin
            if (begin_like) begin
                // storing starts with the trigger cycle itself
                store_now = (state_ff.tracing || trigger) &&
                            (mode_event_only ? cpu_bus.valid : cpu_bus.opfetch) && !fifo_full;
                run_done = fifo_full;
            end else begin
                // circular capture of opcode fetches until the trigger
                store_now = cpu_bus.opfetch;
                run_done = trigger;
            end
        end
    end

    // fifo move: trace capture while armed, profiling read while disarmed
    always_comb begin
        fifo_clear = wr_ctrl && wctrl.capture_arm && !state_ff.run_active_flag;
        fifo_shift = 1'b0;
        fifo_din = 16'h0000;
        if (store_now) begin
            fifo_shift = 1'b1;
            // event-only capture keeps just the bus data byte, with a zero upper byte
            fifo_din = mode_event_only ? {8'h00, cpu_bus.data} : cpu_bus.addr;
        end else if (rd_lower && !state_ff.run_active_flag) begin
            // head leaves, last opcode address enters the tail: eight-read delay
            fifo_shift = 1'b1;
            fifo_din = state_ff.last_op;
        end
        // an armed lower read leaves the fifo where it is
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.brk = 1'b0;
        nxt_state.rst_req = 1'b0;

        // remember the newest opcode fetch address for profiling
        if (cpu_bus.valid && cpu_bus.opfetch) begin
            nxt_state.last_op = cpu_bus.addr;
        end

        // begin traces keep storing once a trigger cycle has itself been stored
        if (store_now && trigger) begin
            nxt_state.tracing = 1'b1;
        end

        // completion clears arm and the run flag, breaking if enabled
        if (run_done) begin
            nxt_state.ctrl.capture_arm = 1'b0;
            nxt_state.run_active_flag = 1'b0;
            nxt_state.tracing = 1'b0;
            nxt_state.brk = state_ff.ctrl.break_request_enable;
        end

        // register writes
        if (reg_req.wr) begin
            unique case (reg_req.sel)
                `DTB_IDX_HOST_RESET: begin
                    // only background commands reach this bit, and only once per reset
                    if (reg_req.bgnd && reg_req.wdata[`DTB_BIT_FORCED_RESET] &&
                        !state_ff.rst_done) begin
                        nxt_state.rst_req = 1'b1;
                        nxt_state.rst_done = 1'b1;
                    end
                end
                `DTB_IDX_CMP_A_UPPER: begin
                    if (!state_ff.ctrl.capture_arm) begin
                        nxt_state.cmp_a[15:8] = reg_req.wdata;
                    end
                end
                `DTB_IDX_CMP_A_LOWER: begin
                    if (!state_ff.ctrl.capture_arm) begin
                        nxt_state.cmp_a[7:0] = reg_req.wdata;
                    end
                end
                `DTB_IDX_CMP_B_UPPER: begin
                    if (!state_ff.ctrl.capture_arm) begin
                        nxt_state.cmp_b[15:8] = reg_req.wdata;
                    end
                end
                `DTB_IDX_CMP_B_LOWER: begin
                    if (!state_ff.ctrl.capture_arm) begin
                        nxt_state.cmp_b[7:0] = reg_req.wdata;
                    end
                end
                `DTB_IDX_FIFO_UPPER, `DTB_IDX_FIFO_LOWER: begin
                    // read-only ports: a write changes nothing
                    nxt_state.ctrl = nxt_state.ctrl;
                end
                `DTB_IDX_CONTROL: begin
                    // writable at any time, no arm restriction
                    nxt_state.ctrl = wctrl;
                    // a secured part keeps the unit disabled
                    nxt_state.ctrl.debug_unit_enable = wctrl.debug_unit_enable && !secure_state;
                    // arming needs the unit enabled
                    nxt_state.ctrl.capture_arm = wctrl.capture_arm && nxt_state.ctrl.debug_unit_enable;
                    if (nxt_state.ctrl.capture_arm) begin
                        // a fresh arm starts a new run
                        if (!state_ff.run_active_flag) begin
                            nxt_state.tracing = 1'b0;
                        end
                        nxt_state.run_active_flag = 1'b1;
                    end else begin
                        // zero in arm or enable stops the run now
                        nxt_state.run_active_flag = 1'b0;
                        nxt_state.tracing = 1'b0;
                    end
                end
            endcase
        end

        // read data is registered one cycle after the read strobe
        if (reg_req.rd) begin
            unique case (reg_req.sel)
                `DTB_IDX_HOST_RESET: nxt_state.rdata = `DTB_READ_ZERO;
                `DTB_IDX_CMP_A_UPPER: nxt_state.rdata = state_ff.cmp_a[15:8];
                `DTB_IDX_CMP_A_LOWER: nxt_state.rdata = state_ff.cmp_a[7:0];
                `DTB_IDX_CMP_B_UPPER: nxt_state.rdata = state_ff.cmp_b[15:8];
                `DTB_IDX_CMP_B_LOWER: nxt_state.rdata = state_ff.cmp_b[7:0];
                // upper read never moves the fifo
                `DTB_IDX_FIFO_UPPER: nxt_state.rdata = mode_event_only ? `DTB_READ_ZERO :
                                                       fifo_head[15:8];
                `DTB_IDX_FIFO_LOWER: nxt_state.rdata = fifo_head[7:0];
                `DTB_IDX_CONTROL: nxt_state.rdata = state_ff.ctrl;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    // everything, the forced reset latch included, returns to zero with system reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata = state_ff.rdata;
    assign run_active_flag = state_ff.run_active_flag;
    assign fifo_valid_count = fifo_count;
    assign break_req = state_ff.brk;
    // kind only matters while breaks are enabled; 0 force, 1 tag
    assign break_is_tag = state_ff.ctrl.break_kind_tag && state_ff.ctrl.break_request_enable;
    assign sys_reset_req = state_ff.rst_req;

endmodule : dtb_top

`default_nettype wire

// ===== common/dtb_consts.svh
// constants for the debug trace and break unit
`ifndef DTB_CONSTS_SVH
`define DTB_CONSTS_SVH

// ****************************************
// register indices on the register port
// ****************************************
`define DTB_IDX_HOST_RESET 3'h0
`define DTB_IDX_CMP_A_UPPER 3'h1
`define DTB_IDX_CMP_A_LOWER 3'h2
`define DTB_IDX_CMP_B_UPPER 3'h3
`define DTB_IDX_CMP_B_LOWER 3'h4
`define DTB_IDX_FIFO_UPPER 3'h5
`define DTB_IDX_FIFO_LOWER 3'h6
`define DTB_IDX_CONTROL 3'h7

// ****************************************
// field positions and reset values
// ****************************************
`define DTB_BIT_FORCED_RESET 0
`define DTB_BIT_ENABLE 7
`define DTB_BIT_ARM 6
`define DTB_RST_BYTE 8'h00
`define DTB_RST_WORD 16'h0000
`define DTB_READ_ZERO 8'h00

// ****************************************
// trace buffer geometry
// ****************************************
`define DTB_FIFO_DEPTH 8
`define DTB_FIFO_WIDTH 16

`endif

// ===== common/dtb_pkg.sv
// types shared by the debug trace and break unit
package dtb_pkg;

    // ****************************************
    // control register layout, bit 7 first
    // ****************************************
    typedef struct packed {
        logic debug_unit_enable;
        logic capture_arm;
        logic break_kind_tag;
        logic break_request_enable;
        logic cmp_a_direction_value;
        logic cmp_a_direction_qualify;
        logic cmp_b_direction_value;
        logic cmp_b_direction_qualify;
    } dtb_ctrl_t;

    // ****************************************
    // register port request
    // ****************************************
    typedef struct packed {
        logic [2:0] sel;
        logic wr;
        logic rd;
        logic bgnd;
        logic [7:0] wdata;
    } dtb_req_t;

    // ****************************************
    // observed cpu bus cycle
    // ****************************************
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic valid;
        logic is_read;
        logic opfetch;
    } dtb_cpu_t;

    // ****************************************
    // whole state of the top module
    // ****************************************
    typedef struct packed {
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        dtb_ctrl_t ctrl;
        logic run_active_flag;
        logic tracing;
        logic brk;
        logic rst_req;
        logic rst_done;
        logic [15:0] last_op;
        logic [7:0] rdata;
    } dtb_state_t;

endpackage : dtb_pkg

// ===== verilog/dtb_comparator.sv
// one address comparator with read/write qualification
`timescale 1ns/1ps
`default_nettype none

module dtb_comparator #(
    parameter int AW = 16
) (
    // compare value and qualification
    input wire logic [AW-1:0] cmp_value,
    input wire logic dir_qualify,
    input wire logic dir_value,
    // observed bus cycle
    input wire logic [AW-1:0] bus_addr,
    input wire logic bus_valid,
    input wire logic bus_is_read,
    // result
    output logic match
);

    // direction is ignored unless qualification is on; 0 = write, 1 = read
    always_comb begin
        match = bus_valid && (bus_addr == cmp_value) &&
                (!dir_qualify || (bus_is_read == dir_value));
    end

endmodule : dtb_comparator

`default_nettype wire

// ===== verilog/dtb_trace_fifo.sv
// eight-word shifting trace buffer with a valid count
`timescale 1ns/1ps
`default_nettype none
`include "dtb_consts.svh"

module dtb_trace_fifo #(
    parameter int W = `DTB_FIFO_WIDTH,
    parameter int DEPTH = `DTB_FIFO_DEPTH
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic clear,
    input wire logic shift,
    input wire logic [W-1:0] din,
    // status and head word
    output logic [W-1:0] head,
    output logic [$clog2(DEPTH):0] count,
    output logic full
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [$clog2(DEPTH):0] cnt;
    } dtb_fifo_state_t;

    dtb_fifo_state_t state_ff;
    dtb_fifo_state_t nxt_state;

    // one shift moves every word toward the head and puts din in the last slot,
    // so the same move serves trace capture and profiling reads
    always_comb begin
        nxt_state = state_ff;
        if (clear) begin
            nxt_state.cnt = '0;
        end
        if (shift) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                nxt_state.mem[i] = state_ff.mem[i+1];
            end
            nxt_state.mem[DEPTH-1] = din;
            if (!clear && state_ff.cnt != DEPTH[$clog2(DEPTH):0]) begin
                nxt_state.cnt = state_ff.cnt + 1'b1;
            end
        end
    end

    // register the state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign head = state_ff.mem[0];
    assign count = state_ff.cnt;
    assign full = (state_ff.cnt == DEPTH[$clog2(DEPTH):0]);

endmodule : dtb_trace_fifo

`default_nettype wire

// ===== bench/dtb_chk.sv
// port checker for the debug trace and break unit
`timescale 1ns/1ps
`default_nettype none

module dtb_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire dtb_pkg::dtb_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // mode inputs
    input wire logic mode_begin_trace,
    input wire logic secure_state,
    // status and requests
    input wire logic run_active_flag,
    input wire logic [3:0] fifo_valid_count,
    input wire logic break_req,
    input wire logic break_is_tag,
    input wire logic sys_reset_req
);
    // ****************************************
    // properties on the top ports
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_rst_reg_zero;
        reg_req.rd && reg_req.sel == 3'h0 |=> reg_rdata == 8'h00;
    endproperty
    a_rst_reg_zero: assert property (p_rst_reg_zero) else $error("host reset register read nonzero");
    property p_user_no_rst;
        reg_req.wr && !reg_req.bgnd && reg_req.sel == 3'h0 |=> !sys_reset_req;
    endproperty
    a_user_no_rst: assert property (p_user_no_rst) else $error("user write caused reset");
    property p_rst_cause;
        $rose(sys_reset_req) |-> $past(reg_req.wr && reg_req.bgnd && reg_req.sel == 3'h0 && reg_req.wdata[0]);
    endproperty
    a_rst_cause: assert property (p_rst_cause) else $error("reset request without host write");
    property p_rst_single;
        sys_reset_req |=> !sys_reset_req;
    endproperty
    a_rst_single: assert property (p_rst_single) else $error("reset request longer than one cycle");
    property p_secure;
        secure_state && reg_req.wr && reg_req.sel == 3'h7 && !run_active_flag |=> !run_active_flag;
    endproperty
    a_secure: assert property (p_secure) else $error("run started while secured");
    property p_arm;
        reg_req.wr && reg_req.sel == 3'h7 && reg_req.wdata[7:6] == 2'h3 && !secure_state && !run_active_flag
            |=> run_active_flag && fifo_valid_count == 4'h0;
    endproperty
    a_arm: assert property (p_arm) else $error("arming did not start a clean run");
    property p_stop;
        reg_req.wr && reg_req.sel == 3'h7 && !(reg_req.wdata[7] && reg_req.wdata[6]) |=> !run_active_flag;
    endproperty
    a_stop: assert property (p_stop) else $error("run not stopped by control write");
    property p_tag;
        reg_req.wr && reg_req.sel == 3'h7 |=> break_is_tag == $past(reg_req.wdata[5] && reg_req.wdata[4]);
    endproperty
    a_tag: assert property (p_tag) else $error("break kind wrong");
    property p_brk_end;
        break_req |-> !run_active_flag && $past(run_active_flag);
    endproperty
    a_brk_end: assert property (p_brk_end) else $error("break not at run completion");
    property p_full_end;
        mode_begin_trace && run_active_flag && fifo_valid_count == 4'h8 |-> ##[1:2] !run_active_flag;
    endproperty
    a_full_end: assert property (p_full_end) else $error("begin trace did not end when full");

    // main scenarios reached
    c_tag_brk: cover property (break_req && break_is_tag);
    c_forced: cover property (sys_reset_req);
    c_full: cover property (run_active_flag && fifo_valid_count == 4'h8);
endmodule : dtb_chk

`default_nettype wire

// ===== bench/dtb_host_model.sv
// debug host model driving the register port
`timescale 1ns/1ps
`default_nettype none

module dtb_host_model (
    // clock
    input wire logic ref_clk,
    // register port
    output var dtb_pkg::dtb_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    // ****************************************
    // host transfers
    // ****************************************
    // idle port from time zero
    initial begin
        reg_req = '0;
    end

    // one transfer held across exactly one taking edge
    task automatic xfer(input logic [2:0] sel, input logic w, input logic [7:0] wd, input logic bg,
                        output logic [7:0] rd);
        @(posedge ref_clk);
        #1;
        reg_req = '{sel, w, !w, bg, wd};
        @(posedge ref_clk);
        #1;
        rd = reg_rdata;
        reg_req = '0;
    endtask : xfer

    // upper first: the lower read shifts the buffer
    task automatic word(output logic [15:0] wv);
        xfer(3'h5, 1'b0, 8'h00, 1'b1, wv[15:8]);
        xfer(3'h6, 1'b0, 8'h00, 1'b1, wv[7:0]);
    endtask : word

    // background command setting the forced reset bit
    task automatic force_reset();
        logic [7:0] d;
        xfer(3'h0, 1'b1, 8'h01, 1'b1, d);
    endtask : force_reset
endmodule : dtb_host_model

`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the debug trace and break unit
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // ****************************************
    // signals, design and host
    // ****************************************
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    dtb_pkg::dtb_req_t reg_req;
    dtb_pkg::dtb_cpu_t cpu_bus;
    logic [7:0] reg_rdata;
    logic mode_begin_trace = 1'b0;
    logic mode_event_only = 1'b0;
    logic secure_state = 1'b0;
    logic run_active_flag;
    logic [3:0] fifo_valid_count;
    logic break_req;
    logic break_is_tag;
    logic sys_reset_req;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int nbrk = 0;
    int nrst = 0;
    logic [7:0] rb;
    logic [7:0] ctl;
    logic [15:0] w;
    logic [15:0] a;
    logic [15:0] t;
    logic [15:0] hist [16];

    // 100 MHz bus clock
    always #5 ref_clk = ~ref_clk;

    dtb_top dut (.ref_clk, .rst, .reg_req, .reg_rdata, .cpu_bus, .mode_begin_trace, .mode_event_only,
                 .secure_state, .run_active_flag, .fifo_valid_count, .break_req, .break_is_tag, .sys_reset_req);
    dtb_host_model host (.ref_clk, .reg_req, .reg_rdata);

    // pulse counters; pre-edge values are read, so no race with the design
    always @(posedge ref_clk) begin
        cycles++;
        if (break_req === 1'b1) nbrk++;
        if (sys_reset_req === 1'b1) nrst++;
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk_byte

    task automatic chk_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    // control readback: enable refused when secured, arm needs enable
    function automatic logic [7:0] exp_ctrl(input logic [7:0] v, input logic sec);
        logic en;
        en = v[7] & ~sec;
        return {en, v[6] & en, v[5:0]};
    endfunction : exp_ctrl

    task automatic reg_wr(input logic [2:0] s, input logic [7:0] d, input logic bg);
        host.xfer(s, 1'b1, d, bg, rb);
    endtask : reg_wr

    task automatic reg_rd(input logic [2:0] s);
        host.xfer(s, 1'b0, 8'h00, 1'b1, rb);
    endtask : reg_rd

    // one cpu bus cycle, opcode fetch when a read
    task automatic bus(input logic [15:0] ad, input logic r, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        cpu_bus = '{ad, d, 1'b1, r, r};
        @(posedge ref_clk);
        #1;
        cpu_bus.valid = 1'b0;
    endtask : bus

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        cpu_bus = '0;
        void'($urandom(11));
        settle(5);
        rst = 1'b0;
        // reset values, trace ports skipped as a lower read shifts the fifo
        for (int s = 0; s < 8; s++) begin
            if (s != 5 && s != 6) begin
                reg_rd(s[2:0]);
                chk_byte("reset value", 8'h00, rb);
            end
        end
        reg_wr(3'h0, 8'h01, 1'b0);
        settle(3);
        chk_byte("user resets", 8'h00, 8'(nrst));
        secure_state = 1'b1;
        reg_wr(3'h7, 8'hC0, 1'b1);
        reg_rd(3'h7);
        chk_byte("secured control", exp_ctrl(8'hC0, 1'b1), rb);
        chk_bit("secured run", 1'b0, run_active_flag);
        secure_state = 1'b0;
        // manual stop through enable and through arm
        for (int i = 0; i < 2; i++) begin
            reg_wr(3'h7, 8'hC0, 1'b1);
            chk_bit("armed", 1'b1, run_active_flag);
            reg_wr(3'h7, i[0] ? 8'h40 : 8'h80, 1'b1);
            chk_bit("stopped", 1'b0, run_active_flag);
        end
        // end trace per comparator, direction and break kind
        for (int i = 0; i < 8; i++) begin
            a = 16'($urandom);
            t = i[2] ? ~a : a;
            reg_wr(3'h1, a[15:8], 1'b0);
            reg_wr(3'h2, a[7:0], 1'b0);
            reg_wr(3'h3, ~a[15:8], 1'b0);
            reg_wr(3'h4, ~a[7:0], 1'b0);
            reg_rd(i[2] ? 3'h3 : 3'h1);
            chk_byte("comparator write", t[15:8], rb);
            ctl = 8'hD0 | (i[1] ? 8'h20 : 8'h00) | (i[2] ? {6'h00, i[0], 1'b1} : {4'h0, i[0], 1'b1, 2'h0});
            reg_wr(3'h7, ctl, 1'b1);
            chk_bit("tag kind", i[1], break_is_tag);
            reg_rd(3'h7);
            chk_byte("armed control", exp_ctrl(ctl, 1'b0), rb);
            reg_wr(i[2] ? 3'h3 : 3'h1, ~t[15:8], 1'b0);
            bus(t, ~i[0], 8'h00);
            settle(2);
            chk_bit("wrong direction", 1'b1, run_active_flag);
            bus(t, i[0], 8'h00);
            settle(3);
            chk_byte("breaks", 8'(i + 1), 8'(nbrk));
            chk_bit("run ended", 1'b0, run_active_flag);
            reg_rd(3'h7);
            chk_byte("control after run", {ctl[7], 1'b0, ctl[5:0]}, rb);
            reg_rd(i[2] ? 3'h3 : 3'h1);
            chk_byte("comparator kept", t[15:8], rb);
        end
        // event-only begin trace: eight data bytes then a break
        mode_event_only = 1'b1;
        mode_begin_trace = 1'b1;
        reg_wr(3'h7, 8'hD0, 1'b1);
        for (int k = 0; k < 8; k++) begin
            hist[k] = 16'($urandom);
            bus(k == 0 ? a : hist[k], 1'b0, hist[k][7:0]);
        end
        settle(3);
        chk_byte("full break", 8'h09, 8'(nbrk));
        chk_byte("valid count", 8'h08, {4'h0, fifo_valid_count});
        for (int k = 0; k < 8; k++) begin
            host.word(w);
            chk_byte("event upper", 8'h00, w[15:8]);
            chk_byte("event lower", hist[k][7:0], w[7:0]);
        end
        mode_event_only = 1'b0;
        mode_begin_trace = 1'b0;
        // profiling while disarmed; first eight words are priming
        reg_wr(3'h7, 8'h80, 1'b1);
        for (int k = 0; k < 16; k++) begin
            hist[k] = 16'($urandom);
            bus(hist[k], 1'b1, 8'h00);
            if (k == 10) begin
                reg_wr(3'h5, 8'($urandom), 1'b0);
                reg_wr(3'h6, 8'($urandom), 1'b0);
            end
            host.word(w);
            if (k > 7) begin
                chk_byte("profile upper", hist[k - 8][15:8], w[15:8]);
                chk_byte("profile lower", hist[k - 8][7:0], w[7:0]);
            end
        end
        // forced reset, then the system answers with a real reset
        host.force_reset();
        settle(3);
        chk_byte("forced resets", 8'h01, 8'(nrst));
        rst = 1'b1;
        settle(2);
        rst = 1'b0;
        reg_rd(3'h7);
        chk_byte("control after reset", 8'h00, rb);
        close_out();
    end
endmodule : tb_top

bind dtb_top dtb_chk u_chk (.ref_clk, .rst, .reg_req, .reg_rdata, .mode_begin_trace, .secure_state,
                            .run_active_flag, .fifo_valid_count, .break_req, .break_is_tag, .sys_reset_req);

`default_nettype wire
